// >>> rtl/spd_pll_ctrl.sv
// system pll divider chain and digital lock detector
// assumes pin clocks arrive as levels, sampled on ref_clk
// Summary of operation
// - pre-divider divides input by 1 to 256
// - feedback divides by M or 2M, M to 32768
// - post-divider passes clock or divides by 2P
// - dividers take encoded values, decoded here
// - lock rises after over seven good comparisons
// - one bad comparison clears count, drops lock
// - input clocks 32 kHz to 25 MHz accepted
// - output spans 1.2 to 150 MHz
// - divided oscillator compared with pre-divided input
// - power-down resets dividers, holds lock low
// - new dividers apply when power-down clears
`default_nettype none
`include "spd_consts.svh"

module spd_pll_ctrl #(
	parameter int NW = `SPD_N_W,
	parameter int MW = `SPD_M_W,
	parameter int PW = `SPD_P_W
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clk_in_pin,
	input wire logic cco_pin,
	input wire logic pll_power_down_bit,
	input wire logic [NW-1:0] ndec,
	input wire logic [MW-1:0] mdec,
	input wire logic [PW-1:0] pdec,
	input wire logic bypass_post,
	input wire logic bypass_cco_div2,
	output logic fb_clk,
	output logic out_clk,
	output logic pll_lock,
	output logic lock_status
);
	logic [2:0] in_sync_q;
	logic [2:0] cco_sync_q;
	logic in_rise;
	logic cco_rise;
	logic [NW-1:0] n_q;
	logic [MW-1:0] m_q;
	logic [PW-1:0] p_q;
	logic run;
	logic half_q;
	logic fb_tick;
	logic [`SPD_PHASE_W-1:0] phase_q;
	logic wait_fb_q;
	logic armed_q;
	logic cmp_bad;
	logic [`SPD_LOCK_CNT_W-1:0] good_q;
	logic lock_q;
	logic [1:0] stat_q;
	spd_pkg::spd_state_t state_q;

	spd_div_if #(.W(NW)) nd();
	spd_div_if #(.W(MW)) md();
	spd_div_if #(.W(PW)) pd();

	// ****************************************
	// decode: stored code is ratio minus one
	// ****************************************
	function automatic logic [MW-1:0] dec_ratio(input logic [MW-1:0] code);
		dec_ratio = code;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			in_sync_q <= '0;
			cco_sync_q <= '0;
		end
		else
		begin
			in_sync_q <= {in_sync_q[1:0], clk_in_pin};
			cco_sync_q <= {cco_sync_q[1:0], cco_pin};
		end
	end

	assign in_rise = in_sync_q[1] && !in_sync_q[2];
	assign cco_rise = cco_sync_q[1] && !cco_sync_q[2];
	assign run = !pll_power_down_bit;

	// ****************************************
	// divider settings, captured in power-down
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			n_q <= `SPD_RST_NDEC;
			m_q <= `SPD_RST_MDEC;
			p_q <= `SPD_RST_PDEC;
		end
		else if (pll_power_down_bit)
		begin
			n_q <= ndec;
			m_q <= dec_ratio(mdec);
			p_q <= pdec;
		end
	end

	assign nd.ratio_m1 = n_q;
	assign nd.run = run;
	assign md.ratio_m1 = m_q;
	assign md.run = run;
	assign pd.ratio_m1 = p_q;
	assign pd.run = run && !bypass_post;

	spd_divider #(.W(NW)) u_ndiv (.ref_clk(ref_clk), .arst_n(arst_n), .src_en(in_rise), .d(nd));
	spd_divider #(.W(MW)) u_mdiv (.ref_clk(ref_clk), .arst_n(arst_n), .src_en(cco_rise), .d(md));
	spd_divider #(.W(PW)) u_pdiv (.ref_clk(ref_clk), .arst_n(arst_n), .src_en(cco_rise), .d(pd));

	// ****************************************
	// optional extra halving in feedback
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			half_q <= 1'b0;
		else if (!run)
			half_q <= 1'b0;
		else if (md.tick && !bypass_cco_div2)
			half_q <= !half_q;
	end

	assign fb_tick = md.tick && (bypass_cco_div2 || half_q);

	// ****************************************
	// output clocks
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fb_clk <= 1'b0;
			out_clk <= 1'b0;
		end
		else if (!run)
		begin
			fb_clk <= 1'b0;
			out_clk <= 1'b0;
		end
		else
		begin
			if (fb_tick)
				fb_clk <= !fb_clk;
			if (bypass_post)
				out_clk <= cco_sync_q[1];
			else if (pd.tick)
				out_clk <= !out_clk;
		end
	end

	// ****************************************
	// phase measurement, reference vs feedback
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_q <= '0;
			wait_fb_q <= 1'b0;
		end
		else if (!run)
		begin
			phase_q <= '0;
			wait_fb_q <= 1'b0;
		end
		else if (nd.tick)
		begin
			phase_q <= '0;
			wait_fb_q <= !fb_tick;
		end
		else if (fb_tick)
			wait_fb_q <= 1'b0;
		else if (wait_fb_q && phase_q != '1)
			phase_q <= phase_q + 1'b1;
	end

	// ****************************************
	// first tick after start judges no window
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			armed_q <= 1'b0;
		else if (!run)
			armed_q <= 1'b0;
		else if (nd.tick)
			armed_q <= 1'b1;
	end

	assign cmp_bad = wait_fb_q || !armed_q || (phase_q > `SPD_PHASE_TOL);

	// ****************************************
	// good counter and lock
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			good_q <= '0;
		else if (!run)
			good_q <= '0;
		else if (nd.tick)
		begin
			if (cmp_bad)
				good_q <= '0;
			else if (good_q != `SPD_LOCK_CNT_W'(`SPD_LOCK_COUNT))
				good_q <= good_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= spd_pkg::SPD_OFF;
		else if (!run)
			state_q <= spd_pkg::SPD_OFF;
		else
		begin
			unique case (state_q)
				spd_pkg::SPD_OFF: state_q <= spd_pkg::SPD_ACQ;
				spd_pkg::SPD_ACQ:
					if (good_q == `SPD_LOCK_CNT_W'(`SPD_LOCK_COUNT))
						state_q <= spd_pkg::SPD_LOCKED;
				spd_pkg::SPD_LOCKED:
					if (nd.tick && cmp_bad)
						state_q <= spd_pkg::SPD_ACQ;
				default: state_q <= spd_pkg::SPD_OFF;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			lock_q <= 1'b0;
		else
			lock_q <= run && state_q == spd_pkg::SPD_LOCKED
				&& !(nd.tick && cmp_bad);
	end

	assign pll_lock = lock_q;

	// ****************************************
	// status bit for software side
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			stat_q <= '0;
		else
			stat_q <= {stat_q[0], lock_q};
	end

	assign lock_status = stat_q[1];
endmodule

`default_nettype wire

// >>> rtl/spd_consts.svh
// constants for the system pll divider and lock logic
// assumes a single 100 MHz ref_clk domain
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH

// ****************************************
// divider ranges
// ****************************************
`define SPD_N_MAX 256
`define SPD_M_MAX 32768
`define SPD_P_MAX 32
`define SPD_N_W 8
`define SPD_M_W 15
`define SPD_P_W 5

// ****************************************
// lock detector
// ****************************************
`define SPD_LOCK_COUNT 8
`define SPD_LOCK_CNT_W 4
`define SPD_PHASE_TOL 8'h04
`define SPD_PHASE_W 8

// ****************************************
// reset values
// ****************************************
`define SPD_RST_NDEC 8'h00
`define SPD_RST_MDEC 15'h0000
`define SPD_RST_PDEC 5'h00

`endif

// >>> rtl/spd_pkg.sv
// types for the system pll divider and lock logic
// assumes spd_consts.svh is on the include path
`default_nettype none
`include "spd_consts.svh"

package spd_pkg;

	// ****************************************
	// loop state
	// ****************************************
	typedef enum logic [1:0] {
		SPD_OFF = 2'b00,
		SPD_ACQ = 2'b01,
		SPD_LOCKED = 2'b10
	} spd_state_t;

endpackage

`default_nettype wire

// >>> rtl/spd_div_if.sv
// interface carrying one divider's settings and its enable pulse
// assumes one clock domain
`default_nettype none

interface spd_div_if #(parameter int W = 8);
	logic [W-1:0] ratio_m1;
	logic run;
	logic tick;
	modport ctl (output ratio_m1, output run, input tick);
	modport div (input ratio_m1, input run, output tick);
endinterface

`default_nettype wire

// >>> rtl/spd_divider.sv
// programmable counter divider giving a one-cycle enable every ratio cycles
// assumes src_en marks the edges of the clock being divided
`default_nettype none

module spd_divider #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic src_en,
	spd_div_if.div d
);
	logic [W-1:0] cnt_q;

	// ****************************************
	// count down, reload on terminal
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_q <= '0;
		else if (!d.run)
			cnt_q <= '0;
		else if (src_en)
		begin
			if (cnt_q == '0)
				cnt_q <= d.ratio_m1;
			else
				cnt_q <= cnt_q - 1'b1;
		end
	end

	assign d.tick = d.run && src_en && (cnt_q == '0);
endmodule

`default_nettype wire

// >>> verification/spd_pll_monitor.sv
// port checker for spd_pll_ctrl
// assumes bind from the bench top, one ref_clk domain
`default_nettype none
module spd_pll_monitor (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic pll_power_down_bit,
	input wire logic bypass_post,
	input wire logic fb_clk,
	input wire logic out_clk,
	input wire logic pll_lock,
	input wire logic lock_status
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] run_q;
	// cycles since power-down cleared
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			run_q <= 6'h00;
		else if (pll_power_down_bit)
			run_q <= 6'h00;
		else if (run_q != 6'h3f)
			run_q <= run_q + 6'h01;
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	a_pd_lock_low: assert property (pll_power_down_bit |=> !pll_lock)
		else $error("lock high in power-down");
	a_pd_fb_held: assert property (pll_power_down_bit [*2] |-> !fb_clk)
		else $error("feedback runs in power-down");
	a_status_lag: assert property (lock_status == $past(pll_lock, 2))
		else $error("status not two cycles behind");
	a_lock_late: assert property ($rose(pll_lock) |-> run_q >= 6'h0e)
		else $error("lock too early");
	a_lock_pd_free: assert property ($rose(pll_lock) |-> !$past(pll_power_down_bit))
		else $error("lock rose from power-down");
	a_pd_exit_low: assert property ($fell(pll_power_down_bit) |-> !pll_lock [*8])
		else $error("lock right after power-down");
	a_fb_spaced: assert property ($changed(fb_clk) ##1 !pll_power_down_bit |-> $stable(fb_clk))
		else $error("feedback toggles back to back");
	a_out_spaced: assert property ($changed(out_clk) ##1 !bypass_post |-> $stable(out_clk))
		else $error("output toggles back to back");
	c_lock: cover property ($rose(pll_lock));
	c_drop: cover property ($fell(pll_lock) && !pll_power_down_bit);
	c_bypass: cover property ($rose(out_clk) && bypass_post);
endmodule
`default_nettype wire

// >>> verification/system_pll_divider_lock_tb.sv
// bench for spd_pll_ctrl, pins made from ref_clk
// assumes rtl package and header on the include path
`default_nettype none
module system_pll_divider_lock_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic clk_in_pin = 1'b0;
	logic cco_pin = 1'b0;
	logic cco_run = 1'b1;
	logic pll_power_down_bit = 1'b1;
	logic [7:0] ndec = 8'h00;
	logic [14:0] mdec = 15'h0000;
	logic [4:0] pdec = 5'h00;
	logic bypass_post = 1'b0;
	logic bypass_cco_div2 = 1'b1;
	logic fb_clk, out_clk, pll_lock, lock_status;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	int ph = 0;
	spd_pll_ctrl DUT (.ref_clk, .arst_n, .clk_in_pin, .cco_pin, .pll_power_down_bit,
		.ndec, .mdec, .pdec, .bypass_post, .bypass_cco_div2, .fb_clk, .out_clk,
		.pll_lock, .lock_status);
	initial
	begin
		forever #5 ref_clk = !ref_clk;
	end
	// pins toggle every 5 cycles, oscillator follows input
	always @(posedge ref_clk)
	begin
		#1;
		ph = (ph == 4) ? 0 : ph + 1;
		if (ph == 0)
		begin
			clk_in_pin = !clk_in_pin;
			cco_pin = cco_run & clk_in_pin;
		end
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			end_of_test();
		end
	end
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	function automatic logic pick(input int s);
		return (s == 0) ? fb_clk : out_clk;
	endfunction
	task automatic rise(input int s, output int n);
		logic p;
		n = 0;
		do
		begin
			p = pick(s);
			@(posedge ref_clk);
			#2;
			n++;
		end while (!(p === 1'b0 && pick(s) === 1'b1) && n < 500);
	endtask
	task automatic per(input int s, input int e);
		int n;
		rise(s, n);
		rise(s, n);
		chk(n == e, "period");
	endtask
	task automatic cfg(input logic [7:0] n, input logic [14:0] m, input logic [4:0] p,
		input logic bp, input logic bd);
		@(posedge ref_clk);
		#1;
		pll_power_down_bit = 1'b1;
		ndec = n;
		mdec = m;
		pdec = p;
		bypass_post = bp;
		bypass_cco_div2 = bd;
		repeat (3) @(posedge ref_clk);
		#1;
		pll_power_down_bit = 1'b0;
	endtask
	// counts feedback toggles until lock
	task automatic lock_wait(output int k);
		int i;
		logic f;
		k = 0;
		f = fb_clk;
		for (i = 0; i < 400 && pll_lock !== 1'b1; i++)
		begin
			@(posedge ref_clk);
			#2;
			if (fb_clk !== f)
				k++;
			f = fb_clk;
		end
	endtask
	task automatic t_lock();
		int k;
		cfg(8'h00, 15'h0000, 5'h00, 1'b0, 1'b1);
		lock_wait(k);
		chk(k == 9, "lock count");
		per(0, 20);
		per(1, 20);
		$display("test lock done");
	endtask
	task automatic t_drop();
		int i;
		int k;
		@(posedge ref_clk);
		#1;
		cco_run = 1'b0;
		for (i = 0; i < 40 && pll_lock !== 1'b0; i++)
		begin
			@(posedge ref_clk);
			#2;
		end
		chk(i <= 20, "lock kept");
		@(posedge ref_clk);
		#1;
		cco_run = 1'b1;
		lock_wait(k);
		chk(k == 9, "relock count");
		$display("test drop done");
	endtask
	task automatic t_pd();
		@(posedge ref_clk);
		#1;
		pll_power_down_bit = 1'b1;
		@(posedge ref_clk);
		#1;
		chk(pll_lock === 1'b0, "lock in power-down");
		chk(lock_status === 1'b1, "status early");
		repeat (2) @(posedge ref_clk);
		#1;
		chk(lock_status === 1'b0, "status late");
		$display("test power-down done");
	endtask
	task automatic t_div();
		cfg(8'h00, 15'h0001, 5'h02, 1'b0, 1'b0);
		per(0, 80);
		per(1, 60);
		cfg(8'h00, 15'h0001, 5'h02, 1'b1, 1'b1);
		per(0, 40);
		per(1, 10);
		@(posedge ref_clk);
		#1;
		mdec = 15'h0000;
		per(0, 40);
		$display("test dividers done");
	endtask
	task automatic t_ndiv();
		int k;
		cfg(8'h01, 15'h0001, 5'h00, 1'b0, 1'b1);
		lock_wait(k);
		chk(k == 9, "pre-divided lock");
		$display("test pre-divider done");
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk);
		#1;
		arst_n = 1'b1;
		t_lock();
		t_drop();
		t_pd();
		t_div();
		t_ndiv();
		end_of_test();
	end
endmodule
bind spd_pll_ctrl spd_pll_monitor u_mon (.ref_clk(ref_clk), .arst_n(arst_n),
	.pll_power_down_bit(pll_power_down_bit), .bypass_post(bypass_post), .fb_clk(fb_clk),
	.out_clk(out_clk), .pll_lock(pll_lock), .lock_status(lock_status));
`default_nettype wire
